/* File: gpwk_idle_wake.sv */
// Idle handshake, clock gating, interrupt and wake merging for one
// 32-channel general-purpose I/O module, with its Avalon-MM slave.
// Assumes the power and clock manager drives idle_req and reports
// when it has stopped the interface clock; all inputs are synchronous.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "gpwk_defs.svh"

// Function
// R1 - Smart idle acks only when fully quiet
// R2 - After ack, idle until manager gates clock
// R3 - Smart idle: no interrupts, wake detection armed
// R4 - Wake-selected transition leaves idle if enabled
// R5 - Force idle acks request unconditionally
// R6 - Force idle: no interrupts, no wake
// R7 - No-idle policy never acknowledges
// R8 - Auto-gating stops register clock when unaccessed
// R9 - Sampling clock gated unless needed or read
// R10 - Four eight-channel groups, gated when undetected
// R11 - Event clock one in N cycles
// R12 - Module off gates all but registers
// R13 - Auto-gating bit decides interface clock gating
// R14 - Two interrupt lines, each with enable
// R15 - Line one main CPU, two media
// R16 - Wake-selected channels merge into one request
// R17 - Unconnected channels read zero, never wake
// R18 - Wake channel sets both status registers
// R19 - Global wake disabled: no wake request
// R20 - Policy code three behaves as no-idle
// R21 - Level handshake; ack drops after withdrawal
module gpwk_idle_wake (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [31:0] pin_in,
    input wire logic idle_req,
    input wire logic iface_clk_stopped,
    output logic idle_ack,
    output logic wake_request,
    output logic irq_out_main_cpu,
    output logic irq_out_media_core,
    output logic iface_clk_en,
    output logic sample_clk_en
);
    // ==========================================================
    // Declarations
    gpwk_pkg::gpwk_state_e state_q;
    gpwk_pkg::gpwk_state_e state_d;
    logic [4:0] module_config_q;
    logic [2:0] ctrl_q;
    logic [31:0] wake_select_q;
    logic [31:0] rise_q;
    logic [31:0] fall_q;
    logic [7:0] debounce_period_q;
    logic [2:0] dbsync_q;
    logic [31:0] sampled_q;
    logic [31:0] prev_q;
    logic [31:0] wake_ref_q;
    logic [31:0] wake_hit_q;
    logic wake_pending_q;
    logic wake_request_q;
    logic idle_ack_q;
    logic waitrequest_q;
    logic [31:0] readdata_q;
    logic iface_clk_en_q;
    logic sample_clk_en_q;
    logic [31:0] status_one;
    logic [31:0] status_two;
    logic [31:0] select_one;
    logic [31:0] select_two;
    logic irq_one;
    logic irq_two;
    logic [3:0] group_tick;

    // Bus decode
    wire access = read || write;
    wire wr_now = write && !waitrequest_q;
    wire rd_now = read && waitrequest_q;
    wire auto_gating = module_config_q[`GPWK_CFG_AUTO_GATING];
    wire wake_enable = module_config_q[`GPWK_CFG_WAKE_ENABLE];
    wire [1:0] idle_policy =
        module_config_q[`GPWK_CFG_POLICY_HI:`GPWK_CFG_POLICY_LO];
    wire module_off = ctrl_q[`GPWK_CTRL_MODULE_OFF];
    wire [1:0] divisor = ctrl_q[`GPWK_CTRL_DIV_HI:`GPWK_CTRL_DIV_LO];

    // Address match shared by every decode below
    function automatic logic gpwk_hit(input logic [7:0] addr,
                                      input logic [7:0] off);
        gpwk_hit = (addr == off);
    endfunction

    wire wr_cfg = wr_now && gpwk_hit(address, `GPWK_OFF_MODULE_CONFIG);
    wire wr_ctrl = wr_now && gpwk_hit(address, `GPWK_OFF_CTRL);
    wire wr_st1 = wr_now && gpwk_hit(address, `GPWK_OFF_STATUS_ONE);
    wire wr_st2 = wr_now && gpwk_hit(address, `GPWK_OFF_STATUS_TWO);
    wire wr_sel1 = wr_now && gpwk_hit(address, `GPWK_OFF_SELECT_ONE);
    wire wr_sel2 = wr_now && gpwk_hit(address, `GPWK_OFF_SELECT_TWO);
    wire wr_wake = wr_now && gpwk_hit(address, `GPWK_OFF_WAKE_SELECT);
    wire wr_rise = wr_now && gpwk_hit(address, `GPWK_OFF_RISE_DETECT);
    wire wr_fall = wr_now && gpwk_hit(address, `GPWK_OFF_FALL_DETECT);
    wire wr_db = wr_now && gpwk_hit(address, `GPWK_OFF_DEBOUNCE);
    wire rd_sampled = read && gpwk_hit(address, `GPWK_OFF_SAMPLED);

    // Policy and activity
    wire in_idle = (state_q == gpwk_pkg::GPWK_ST_IDLE);
    wire pol_smart = (idle_policy == `GPWK_POLICY_SMART);
    wire pol_force = (idle_policy == `GPWK_POLICY_FORCE);
    // Inactive: force idle acknowledged, nothing may run
    wire inactive = in_idle && pol_force; // R6
    wire run = !module_off && !inactive; // R12
    wire dbsync_pending = (dbsync_q != `GPWK_DBSYNC_ZERO);
    wire [31:0] pins = pin_in & `GPWK_CONNECTED_MASK; // R17
    wire capture_done = (sampled_q == pins);
    wire quiet_smart = capture_done && !(|status_one) &&
        !(|status_two) && !dbsync_pending && !wake_pending_q; // R1
    wire [31:0] detect_any = rise_q | fall_q;
    wire any_group = |detect_any;

    // Per-channel group tick, so each group samples on its own enable
    wire [31:0] chan_tick;
    genvar c;
    generate
        for (c = 0; c < 32; c++)
        begin : g_chan
            assign chan_tick[c] = group_tick[c / `GPWK_GROUP_W];
        end
    endgenerate

    // Edge events on detecting channels at their group tick
    wire [31:0] edge_evt = chan_tick & ((sampled_q & ~prev_q & rise_q) |
        (~sampled_q & prev_q & fall_q));
    // Wake channels: transition against the snapshot taken at idle
    wire [31:0] wake_evt = (pins ^ wake_ref_q) & wake_select_q &
        `GPWK_CONNECTED_MASK; // R16 R17
    wire wake_armed = in_idle && pol_smart && wake_enable; // R3 R19
    wire wake_fire = wake_armed && (|wake_evt); // R4
    // Wake hits land in status once the interface clock runs again
    wire [31:0] wake_set = (!in_idle && !iface_clk_stopped &&
        wake_pending_q) ? wake_hit_q : `GPWK_WORD_RESET; // R18
    wire [31:0] set_vec = (run ? edge_evt : `GPWK_WORD_RESET) | wake_set;

    // ==========================================================
    // Read mux, reserved bits read zero
    wire [31:0] rd_mux =
        gpwk_hit(address, `GPWK_OFF_MODULE_CONFIG) ? {27'h0, module_config_q} :
        gpwk_hit(address, `GPWK_OFF_CTRL) ? {29'h0, ctrl_q} :
        gpwk_hit(address, `GPWK_OFF_STATUS_ONE) ? status_one :
        gpwk_hit(address, `GPWK_OFF_STATUS_TWO) ? status_two :
        gpwk_hit(address, `GPWK_OFF_SELECT_ONE) ? select_one :
        gpwk_hit(address, `GPWK_OFF_SELECT_TWO) ? select_two :
        gpwk_hit(address, `GPWK_OFF_WAKE_SELECT) ? wake_select_q :
        gpwk_hit(address, `GPWK_OFF_SAMPLED) ? sampled_q :
        gpwk_hit(address, `GPWK_OFF_RISE_DETECT) ? rise_q :
        gpwk_hit(address, `GPWK_OFF_FALL_DETECT) ? fall_q :
        gpwk_hit(address, `GPWK_OFF_DEBOUNCE) ? {24'h0, debounce_period_q} :
        gpwk_hit(address, `GPWK_OFF_IDLE_STATUS) ?
            {24'h0, group_tick, dbsync_pending, wake_pending_q, idle_ack_q,
             in_idle} :
        `GPWK_WORD_RESET;

    // ==========================================================
    // Avalon slave: one wait cycle, then the answer edge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            waitrequest_q <= 1'b1;
            readdata_q <= `GPWK_WORD_RESET;
        end
        else if (ce)
        begin
            waitrequest_q <= !(access && waitrequest_q);
            if (rd_now)
                readdata_q <= rd_mux;
        end
    end

    // Configuration registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            module_config_q <= `GPWK_CFG_RESET;
            ctrl_q <= `GPWK_CTRL_RESET;
            wake_select_q <= `GPWK_WORD_RESET;
            rise_q <= `GPWK_WORD_RESET;
            fall_q <= `GPWK_WORD_RESET;
            debounce_period_q <= `GPWK_DEBOUNCE_RESET;
        end
        else if (ce)
        begin
            if (wr_cfg)
                module_config_q <= writedata[4:0];
            if (wr_ctrl)
                ctrl_q <= writedata[2:0];
            if (wr_wake)
                wake_select_q <= writedata & `GPWK_CONNECTED_MASK; // R17
            if (wr_rise)
                rise_q <= writedata;
            if (wr_fall)
                fall_q <= writedata;
            if (wr_db)
                debounce_period_q <= writedata[`GPWK_DEBOUNCE_W-1:0];
        end
    end

    // Debounce write crossing time; blocks smart idle meanwhile
    always_ff @(posedge mclk)
    begin
        if (rst)
            dbsync_q <= `GPWK_DBSYNC_ZERO;
        else if (ce)
            dbsync_q <= wr_db ? `GPWK_DBSYNC_CYCLES :
                (dbsync_pending ? dbsync_q - 3'h1 : dbsync_q); // R1
    end

    // ==========================================================
    // Input sampling, only while its clock would run
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sampled_q <= `GPWK_WORD_RESET;
            prev_q <= `GPWK_WORD_RESET;
        end
        else if (ce && sample_clk_en_q)
        begin
            sampled_q <= pins; // R9
            prev_q <= (prev_q & ~chan_tick) | (sampled_q & chan_tick);
        end
    end

    // ==========================================================
    // Idle handshake
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            gpwk_pkg::GPWK_ST_ACTIVE:
                // Code three falls in with no-idle: never acks
                if (idle_req && (pol_force || (pol_smart && quiet_smart)))
                    state_d = gpwk_pkg::GPWK_ST_IDLE; // R1 R5 R7 R20
            gpwk_pkg::GPWK_ST_IDLE:
                if (!idle_req || wake_fire)
                    state_d = gpwk_pkg::GPWK_ST_ACTIVE; // R21 R4
        endcase
    end

    // Ack held through idle so the manager may gate the clock
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_q <= gpwk_pkg::GPWK_ST_ACTIVE;
            idle_ack_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            idle_ack_q <= (state_d == gpwk_pkg::GPWK_ST_IDLE); // R2 R21
        end
    end

    // ==========================================================
    // Wake request: held until the manager drops its request
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wake_request_q <= 1'b0;
            wake_ref_q <= `GPWK_WORD_RESET;
            wake_hit_q <= `GPWK_WORD_RESET;
            wake_pending_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!in_idle)
                wake_ref_q <= pins;
            if (wake_fire)
            begin
                wake_request_q <= 1'b1; // R16 R19
                wake_hit_q <= wake_evt;
                wake_pending_q <= 1'b1;
            end
            else
            begin
                if (!idle_req)
                    wake_request_q <= 1'b0;
                if (|wake_set)
                    wake_pending_q <= 1'b0; // R18
            end
        end
    end

    // ==========================================================
    // Clock-gating enables seen by the clock tree
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            iface_clk_en_q <= 1'b1;
            sample_clk_en_q <= 1'b1;
        end
        else if (ce)
        begin
            // Auto-gating alone decides; module off leaves it alone
            iface_clk_en_q <= !auto_gating || access; // R8 R13 R12
            sample_clk_en_q <= run && (any_group || rd_sampled || !capture_done); // R9 R12
        end
    end

    // ==========================================================
    // Event clock groups and the two interrupt lines
    gpwk_event_clock u_event_clock (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .run(run),
        .divisor(divisor),
        .detect_any(detect_any),
        .group_tick(group_tick)
    );

    // Line one serves the main processor
    gpwk_status_bank u_bank_one (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .set_vec(set_vec),
        .clr_wr(wr_st1),
        .sel_wr(wr_sel1),
        .wdata(writedata),
        .quiet(in_idle),
        .status(status_one),
        .select(select_one),
        .irq(irq_one)
    );

    // Line two serves the media accelerator
    gpwk_status_bank u_bank_two (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .set_vec(set_vec),
        .clr_wr(wr_st2),
        .sel_wr(wr_sel2),
        .wdata(writedata),
        .quiet(in_idle),
        .status(status_two),
        .select(select_two),
        .irq(irq_two)
    );

    // Outputs, all from flops
    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;
    assign idle_ack = idle_ack_q;
    assign wake_request = wake_request_q;
    assign irq_out_main_cpu = irq_one; // R15
    assign irq_out_media_core = irq_two; // R15
    assign iface_clk_en = iface_clk_en_q;
    assign sample_clk_en = sample_clk_en_q;
endmodule // gpwk_idle_wake
`default_nettype wire

/* File: gpwk_defs.svh */
// Constants of the idle, wake and interrupt control block.
// Included by bare name; definitions only.
`ifndef GPWK_DEFS_SVH
`define GPWK_DEFS_SVH

// ==========================================================
// Register byte offsets
`define GPWK_OFF_MODULE_CONFIG 8'h00
`define GPWK_OFF_CTRL 8'h04
`define GPWK_OFF_STATUS_ONE 8'h08
`define GPWK_OFF_STATUS_TWO 8'h0c
`define GPWK_OFF_SELECT_ONE 8'h10
`define GPWK_OFF_SELECT_TWO 8'h14
`define GPWK_OFF_WAKE_SELECT 8'h18
`define GPWK_OFF_SAMPLED 8'h1c
`define GPWK_OFF_RISE_DETECT 8'h20
`define GPWK_OFF_FALL_DETECT 8'h24
`define GPWK_OFF_DEBOUNCE 8'h28
`define GPWK_OFF_IDLE_STATUS 8'h2c

// ==========================================================
// Field positions
`define GPWK_CFG_AUTO_GATING 0
`define GPWK_CFG_WAKE_ENABLE 2
`define GPWK_CFG_POLICY_LO 3
`define GPWK_CFG_POLICY_HI 4
`define GPWK_CTRL_MODULE_OFF 0
`define GPWK_CTRL_DIV_LO 1
`define GPWK_CTRL_DIV_HI 2

// ==========================================================
// Idle policy codes
`define GPWK_POLICY_FORCE 2'h0
`define GPWK_POLICY_NONE 2'h1
`define GPWK_POLICY_SMART 2'h2

// ==========================================================
// Reset values and widths
`define GPWK_CFG_RESET 5'h00
`define GPWK_CTRL_RESET 3'h0
`define GPWK_WORD_RESET 32'h0000_0000
`define GPWK_DEBOUNCE_RESET 8'h00
`define GPWK_DEBOUNCE_W 8
`define GPWK_GROUPS 4
`define GPWK_GROUP_W 8
// Channels with an external connection; others read 0, never wake
`define GPWK_CONNECTED_MASK 32'hffff_fffe
// Cycles a debounce period write needs to reach the slow domain
`define GPWK_DBSYNC_CYCLES 3'h4
`define GPWK_DBSYNC_ZERO 3'h0

`endif

/* File: gpwk_pkg.sv */
// Types shared by the idle, wake and interrupt control block.
// Assumes nothing of its surroundings.
package gpwk_pkg;
    // Idle handshake states
    typedef enum logic [0:0] {
        GPWK_ST_ACTIVE,
        GPWK_ST_IDLE
    } gpwk_state_e;
endpackage

/* File: gpwk_event_clock.sv */
// Event-detection clock enables: one-in-N divider and four groups.
// Assumes a single clock; the enables qualify flops, not clocks.
`timescale 1ns/10ps
`default_nettype none
`include "gpwk_defs.svh"

module gpwk_event_clock (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    input wire logic [1:0] divisor,
    input wire logic [31:0] detect_any,
    output logic [3:0] group_tick
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [2:0] last;
    logic tick;

    // Terminal count is N-1 for N of 1, 2, 4 or 8
    function automatic logic [2:0] gpwk_last(input logic [1:0] sel);
        gpwk_last = 3'(({1'b0, 2'b00} | 3'h1) << sel) - 3'h1;
    endfunction

    // ==========================================================
    // Divider
    assign last = gpwk_last(divisor);
    assign tick = run && (cnt_q == last); // R11
    assign cnt_d = (cnt_q >= last) ? 3'h0 : cnt_q + 3'h1;

    // Counter frozen while the module is off or inactive
    always_ff @(posedge mclk)
    begin
        if (rst)
            cnt_q <= 3'h0;
        else if (ce && run)
            cnt_q <= cnt_d;
    end

    // ==========================================================
    // Group enables: a group without any detection stays gated
    genvar g;
    generate
        for (g = 0; g < `GPWK_GROUPS; g++)
        begin : g_group
            assign group_tick[g] = tick &&
                |detect_any[g*`GPWK_GROUP_W +: `GPWK_GROUP_W]; // R10
        end
    endgenerate
endmodule // gpwk_event_clock
`default_nettype wire

/* File: gpwk_status_bank.sv */
// One interrupt line: sticky status, channel select, merged output.
// Assumes the bus slave hands over one-cycle write strobes.
`timescale 1ns/10ps
`default_nettype none
`include "gpwk_defs.svh"

module gpwk_status_bank (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [31:0] set_vec,
    input wire logic clr_wr,
    input wire logic sel_wr,
    input wire logic [31:0] wdata,
    input wire logic quiet,
    output logic [31:0] status,
    output logic [31:0] select,
    output logic irq
);
    logic [31:0] status_q;
    logic [31:0] select_q;
    logic irq_q;
    logic [31:0] clr_vec;

    // Write one to clear; a set in the same cycle wins
    assign clr_vec = clr_wr ? wdata : `GPWK_WORD_RESET;

    // ==========================================================
    // Status, select and the merged line
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            status_q <= `GPWK_WORD_RESET;
            select_q <= `GPWK_WORD_RESET;
            irq_q <= 1'b0;
        end
        else if (ce)
        begin
            status_q <= (status_q & ~clr_vec) | set_vec;
            if (sel_wr)
                select_q <= wdata;
            // Line follows status one cycle later, muted while idle
            irq_q <= |(status_q & select_q) && !quiet; // R14 R3 R6
        end
    end

    assign status = status_q;
    assign select = select_q;
    assign irq = irq_q;
endmodule // gpwk_status_bank
`default_nettype wire

/* File: gpwk_idle_wake_assertions.sv */
// Port-level checker for the idle link, bus timing and wake logic.
// Assumes one clock domain and a bind from the testbench top file.
`timescale 1ns/10ps
`default_nettype none

module gpwk_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic waitrequest,
    input wire logic idle_req,
    input wire logic iface_clk_stopped,
    input wire logic idle_ack,
    input wire logic wake_request,
    input wire logic irq_out_main_cpu,
    input wire logic irq_out_media_core,
    input wire logic iface_clk_en
);
    // ==========
    // Shadow of the configuration word
    logic [4:0] cfg_q;
    wire logic cfg_hit = ce && write && !waitrequest && address == 8'h00;

    // Follows committed writes only
    always_ff @(posedge mclk)
    begin
        if (rst)
            cfg_q <= 5'h00;
        else if (cfg_hit)
            cfg_q <= writedata[4:0];
    end

    // ==========
    // Assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    ack_cause_a: assert property ($rose(idle_ack) |-> $past(idle_req))
        else $error("idle ack rose without a request");
    ack_drop_a: assert property (ce && !idle_req |=> !idle_ack)
        else $error("idle ack kept after withdrawal");
    no_idle_a: assert property (ce && cfg_q[3] |=> !idle_ack)
        else $error("idle ack under a no-idle policy");
    wait_one_a: assert property (ce && (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer not after one wait cycle");
    irq_quiet_a: assert property (idle_ack && iface_clk_stopped |=>
        !(irq_out_main_cpu || irq_out_media_core))
        else $error("interrupt raised while idle");
    wake_hold_a: assert property (ce && wake_request && idle_req |=> wake_request)
        else $error("wake request dropped early");
    wake_idle_a: assert property ($rose(wake_request) |-> $past(idle_ack))
        else $error("wake request outside idle");
    wake_block_a: assert property (ce && !wake_request &&
        (!cfg_q[2] || cfg_q[4:3] == 2'h0) |=> !wake_request)
        else $error("wake request while wake is blocked");
    auto_gate_a: assert property (ce && cfg_q[0] && !read && !write |=> !iface_clk_en)
        else $error("register clock runs while unaccessed");
    ungated_a: assert property (ce && !cfg_q[0] |=> iface_clk_en)
        else $error("register clock gated without auto gating");

    wake_c: cover property ($rose(wake_request));
    ack_c: cover property ($rose(idle_ack));
    media_c: cover property ($rose(irq_out_media_core));
endmodule // gpwk_checker
`default_nettype wire

/* File: gpwk_mgr_model.sv */
// Model of the power and clock manager on the idle link.
// Assumes the bench asks for idle on want and sets the gate delay.
`timescale 1ns/10ps
`default_nettype none

module gpwk_mgr_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic want,
    input wire logic [3:0] gate_delay,
    input wire logic idle_ack,
    input wire logic wake_request,
    output logic idle_req,
    output logic iface_clk_stopped
);
    // ==========
    // Request, clock gate and wake bookkeeping
    logic [3:0] cnt_q;
    logic woke_q;

    // Gate delay stands for slower peers sharing the clock domain
    always_ff @(posedge mclk)
    begin
        if (rst || !want)
        begin
            idle_req <= 1'b0;
            iface_clk_stopped <= 1'b0;
            cnt_q <= 4'h0;
            woke_q <= 1'b0;
        end
        else if (wake_request || woke_q)
        begin
            idle_req <= 1'b0;
            iface_clk_stopped <= 1'b0;
            woke_q <= 1'b1;
        end
        else
        begin
            idle_req <= 1'b1;
            if (idle_ack && cnt_q != gate_delay)
                cnt_q <= cnt_q + 4'h1;
            iface_clk_stopped <= idle_ack && cnt_q == gate_delay;
        end
    end
endmodule // gpwk_mgr_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the idle, wake and interrupt control block.
// Assumes the checker and manager model are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module tb;
    // ==========
    // Bench signals; the manager model drives the idle link
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic read = 1'b0;
    logic write = 1'b0;
    logic want = 1'b0;
    logic [3:0] gate_delay = 4'h2;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] pin_in = 32'h0;
    logic [31:0] readdata;
    logic waitrequest, idle_req, iface_clk_stopped, idle_ack, wake_request;
    logic irq_out_main_cpu, irq_out_media_core, iface_clk_en, sample_clk_en;
    int n_fail = 0;
    int checks_done = 0;

    gpwk_idle_wake i_dut (
        .mclk, .rst, .ce, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .pin_in, .idle_req, .iface_clk_stopped, .idle_ack, .wake_request,
        .irq_out_main_cpu, .irq_out_media_core, .iface_clk_en, .sample_clk_en
    );
    gpwk_mgr_model i_mgr (
        .mclk, .rst, .want, .gate_delay, .idle_ack, .wake_request, .idle_req,
        .iface_clk_stopped
    );

    // Interface clock, 5 ns period
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end

    // ==========
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h, expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle; a read compares its data with d
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge mclk);
        while (waitrequest !== 1'b0)
            @(posedge mclk);
        if (!wr)
            chk(readdata, d);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Bounded wait on wake (w=1) or idle ack (w=0)
    task automatic wait_on(input logic w, input logic e);
        for (int i = 0; i < 20 && (w ? wake_request : idle_ack) !== e; i++)
            @(negedge mclk);
        chk(w ? wake_request : idle_ack, e);
        @(posedge mclk);
    endtask

    // ==========
    // Scenarios
    task automatic t_pins;
        bus(1'b1, 8'h18, 32'hffff_ffff);
        bus(1'b0, 8'h18, 32'hffff_fffe);
        pin_in <= 32'h8000_0001;
        step(6);
        bus(1'b0, 8'h1c, 32'h8000_0000);
        pin_in <= 32'h0;
        bus(1'b1, 8'h18, 32'h200);
    endtask

    // Divided event clock, both lines, then module off
    task automatic t_irq;
        bus(1'b1, 8'h04, 32'h6);
        bus(1'b0, 8'h04, 32'h6);
        bus(1'b1, 8'h20, 32'h20);
        bus(1'b1, 8'h10, 32'h20);
        pin_in[5] <= 1'b1;
        step(24);
        chk(irq_out_main_cpu, 1'b1);
        chk(irq_out_media_core, 1'b0);
        bus(1'b0, 8'h0c, 32'h20);
        bus(1'b1, 8'h08, 32'hffff_ffff);
        bus(1'b1, 8'h04, 32'h1);
        pin_in[5] <= 1'b0;
        step(4);
        pin_in[5] <= 1'b1;
        step(20);
        bus(1'b0, 8'h08, 32'h0);
        chk(sample_clk_en, 1'b0);
        bus(1'b0, 8'h40, 32'h0);
        bus(1'b1, 8'h04, 32'h0);
    endtask

    task automatic t_no_idle;
        logic [31:0] cfg [2] = '{32'h08, 32'h18};
        foreach (cfg[i])
        begin
            bus(1'b1, 8'h00, cfg[i]);
            want <= 1'b1;
            step(20);
            chk(idle_ack, 1'b0);
            want <= 1'b0;
            step(2);
        end
    endtask

    // Force idle with an interrupt pending
    task automatic t_force;
        pin_in[5] <= 1'b0;
        step(4);
        pin_in[5] <= 1'b1;
        step(12);
        bus(1'b1, 8'h00, 32'h4);
        want <= 1'b1;
        wait_on(1'b0, 1'b1);
        step(8);
        chk(irq_out_main_cpu, 1'b0);
        pin_in[9] <= 1'b1;
        step(10);
        chk(wake_request, 1'b0);
        want <= 1'b0;
        wait_on(1'b0, 1'b0);
    endtask

    // Smart idle refused while busy, then woken by channel 9
    task automatic t_smart;
        bus(1'b1, 8'h00, 32'h14);
        bus(1'b1, 8'h14, 32'h200);
        gate_delay <= 4'h9;
        want <= 1'b1;
        step(20);
        chk(idle_ack, 1'b0);
        bus(1'b1, 8'h08, 32'hffff_ffff);
        bus(1'b1, 8'h0c, 32'hffff_ffff);
        wait_on(1'b0, 1'b1);
        step(14);
        pin_in[9] <= 1'b0;
        wait_on(1'b1, 1'b1);
        wait_on(1'b0, 1'b0);
        want <= 1'b0;
        step(4);
        bus(1'b0, 8'h08, 32'h200);
        bus(1'b0, 8'h0c, 32'h200);
        chk(irq_out_media_core, 1'b1);
        chk(irq_out_main_cpu, 1'b0);
    endtask

    task automatic t_wake_off;
        bus(1'b1, 8'h0c, 32'hffff_ffff);
        bus(1'b1, 8'h08, 32'hffff_ffff);
        bus(1'b1, 8'h00, 32'h10);
        gate_delay <= 4'h0;
        want <= 1'b1;
        wait_on(1'b0, 1'b1);
        pin_in[9] <= 1'b1;
        step(10);
        chk(wake_request, 1'b0);
        want <= 1'b0;
        wait_on(1'b0, 1'b0);
    endtask

    task automatic t_gate;
        bus(1'b1, 8'h00, 32'h1);
        step(3);
        chk(iface_clk_en, 1'b0);
        bus(1'b0, 8'h00, 32'h1);
        bus(1'b1, 8'h00, 32'h0);
        step(3);
        chk(iface_clk_en, 1'b1);
    endtask

    task automatic stop_test;
        $display("Counts: %0d failed of %0d checks", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence after a three-cycle reset
    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_pins;
        t_irq;
        t_no_idle;
        t_force;
        t_smart;
        t_wake_off;
        t_gate;
        stop_test;
    end

    // Watchdog at 100 us, some sixty times the expected run
    initial
    begin
        #100000;
        n_fail++;
        stop_test;
    end
endmodule // tb

bind gpwk_idle_wake gpwk_checker i_chk (
    .mclk, .rst, .ce, .address, .read, .write, .writedata, .waitrequest, .idle_req,
    .iface_clk_stopped, .idle_ack, .wake_request, .irq_out_main_cpu,
    .irq_out_media_core, .iface_clk_en
);
`default_nettype wire
